// [hw/sync_sram_control_inputs.sv]
`timescale 1ns/100ps
// Overview of operation
// - The full address, two low bits too, is captured and picks the word.
// - Each lane write select is active low and sampled on the edge.
// - Lane write select n governs only data byte n and parity bit n.
// - A lane is written only with both the write request and its select.
// - The write request is active low and taken only on qualified edges.
// - Advance/load high on a qualified edge steps the burst counter while selected.
// - Advance/load low on a qualified edge loads the presented address if all selects are active, else deselects.
// - Inputs are captured on the clock; an edge is ignored if unqualified.
// - The first select is active low, sampled and joined with the others.
// - The second select is active high; selection needs all three active.
// - The third select is active low and sampled for the same decision.
// - A high qualifier does not deselect; address, burst and select state hold meanwhile, and the access pulses drop.
// - Strap high gives interleaved order, low gives linear; nothing pulls a floating strap high.
module sync_sram_control_inputs #(
    parameter int ADDR_W = sram_ctl_pkg::ADDR_W,
    parameter int LANES = sram_ctl_pkg::LANES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:2] addr_upper,
    input wire logic addr_bit_one,
    input wire logic addr_bit_zero,
    input wire logic [LANES-1:0] lane_write_sel_n,
    input wire logic write_req_n,
    input wire logic advance_or_load,
    input wire logic clock_qualifier_low,
    input wire logic select_low_first,
    input wire logic select_high_second,
    input wire logic select_low_third,
    input wire logic burst_order_strap,
    output logic [ADDR_W-1:0] access_addr,
    output logic access_valid,
    output logic access_write,
    output logic [LANES-1:0] lane_write_en,
    output logic selected
);
    // Width of all pins packed for the synchroniser
    localparam int PIN_W = ADDR_W + LANES + 7;

    // All state: synchroniser stages, burst tracking and output pulses
    typedef struct packed {
        logic [PIN_W-1:0] meta; // First synchroniser stage
        logic [PIN_W-1:0] sync; // Second synchroniser stage
        logic [ADDR_W-1:0] base; // Loaded address; low bits start burst
        logic [1:0] ofs; // Low address bits now presented
        logic [1:0] cnt; // Burst position since the load
        logic sel; // Device selected
        logic wr; // Loaded access is a write
        logic mode; // Latched burst order
        logic mode_taken; // Strap already latched
        logic valid; // Access pulse
        logic wr_pulse; // Write pulse
        logic [LANES-1:0] lane_en; // Lane write pulse
    } state_s;

    state_s st_q;
    state_s st_d;

    // Synchronised pin fields, read from the second stage only
    logic [ADDR_W-1:0] s_addr;
    logic [LANES-1:0] s_lane_sel_n;
    logic s_write_n;
    logic s_advance;
    logic s_qual_n;
    logic s_sel1_n;
    logic s_sel2;
    logic s_sel3_n;
    logic s_mode;

    assign {s_addr, s_lane_sel_n, s_write_n, s_advance, s_qual_n, s_sel1_n,
        s_sel2, s_sel3_n, s_mode} = st_q.sync;

    // Next state: capture, load, advance, deselect, stall and reset
    always_comb begin
        logic all_sel;
        logic [1:0] step_cnt;
        all_sel = 1'b0;
        step_cnt = 2'h0;
        st_d = st_q;

        // Pins pass two flops before any logic reads them
        st_d.meta = {addr_upper, addr_bit_one, addr_bit_zero,
            lane_write_sel_n, write_req_n, advance_or_load,
            clock_qualifier_low, select_low_first, select_high_second,
            select_low_third, burst_order_strap};
        st_d.sync = st_q.meta;

        // Access pulses last one cycle
        st_d.valid = 1'b0;
        st_d.wr_pulse = 1'b0;
        st_d.lane_en = '0;

        // Strap caught once, from an already flushed synchroniser
        if (!st_q.mode_taken) begin
            st_d.mode = s_mode;
            st_d.mode_taken = 1'b1;
        end

        // Three-way select decision
        all_sel = !s_sel1_n && s_sel2 && !s_sel3_n;

        // Next burst position, wrapping within four
        step_cnt = st_q.cnt + 2'h1;

        // Edge ignored while qualifier high; address, burst and select state held, pulses cleared
        if (!s_qual_n) begin
            if (!s_advance) begin
                if (all_sel) begin
                    // Load new access
                    st_d.base = s_addr;
                    st_d.ofs = s_addr[1:0];
                    st_d.cnt = 2'h0;
                    st_d.sel = 1'b1;
                    st_d.wr = !s_write_n; // Write only on low request
                    st_d.valid = 1'b1;
                    st_d.wr_pulse = !s_write_n;
                    // Lane n follows its own select only
                    st_d.lane_en = {LANES{!s_write_n}} & ~s_lane_sel_n;
                end else begin
                    // Deselect, no access
                    st_d.sel = 1'b0;
                    st_d.wr = 1'b0;
                end
            end else if (st_q.sel) begin
                // Step burst counter in strap order
                st_d.cnt = step_cnt;
                if (st_q.mode == sram_ctl_pkg::ORDER_INTERLEAVED) begin
                    st_d.ofs = st_q.base[1:0] ^ step_cnt;
                end else begin
                    st_d.ofs = st_q.base[1:0] + step_cnt;
                end
                st_d.valid = 1'b1;
                st_d.wr_pulse = st_q.wr;
                // Burst keeps its type; lanes follow new selects
                st_d.lane_en = {LANES{st_q.wr}} & ~s_lane_sel_n;
            end
        end

        // Synchronous reset; synchroniser runs on so pins are flushed
        if (rst) begin
            st_d.base = '0;
            st_d.ofs = sram_ctl_pkg::BURST_OFS_RST;
            st_d.cnt = 2'h0;
            st_d.sel = 1'b0;
            st_d.wr = 1'b0;
            st_d.mode = sram_ctl_pkg::ORDER_INTERLEAVED;
            st_d.mode_taken = 1'b0;
            st_d.valid = 1'b0;
            st_d.wr_pulse = 1'b0;
            st_d.lane_en = '0;
        end
    end

    // State register, loaded on every edge
    always_ff @(posedge core_clk) begin
        st_q <= st_d;
    end

    // Outputs straight from the state flops
    assign access_addr = {st_q.base[ADDR_W-1:2], st_q.ofs};
    assign access_valid = st_q.valid;
    assign access_write = st_q.wr_pulse;
    assign lane_write_en = st_q.lane_en;
    assign selected = st_q.sel;

    property p_stall_hold;
        @(posedge core_clk) disable iff (rst)
        s_qual_n |=> (st_q.ofs == $past(st_q.ofs)) && !access_valid;
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("State moved on a stalled edge");

    property p_write_needs_req;
        @(posedge core_clk) disable iff (rst)
        (lane_write_en != '0) |-> access_write;
    endproperty
    a_write_needs_req: assert property (p_write_needs_req)
        else $error("Lane write without write request");

    property p_deselect;
        @(posedge core_clk) disable iff (rst)
        (!s_qual_n && !s_advance && !(!s_sel1_n && s_sel2 && !s_sel3_n))
        |=> !access_valid && !selected;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("Access started while deselected");

    property p_load;
        @(posedge core_clk) disable iff (rst)
        (!s_qual_n && !s_advance && !s_sel1_n && s_sel2 && !s_sel3_n)
        |=> access_valid && (access_addr == $past(s_addr));
    endproperty
    a_load: assert property (p_load)
        else $error("Presented address not loaded");

    property p_lane_map;
        @(posedge core_clk) disable iff (rst)
        (!s_qual_n && !s_advance && !s_sel1_n && s_sel2 && !s_sel3_n
        && !s_write_n)
        |=> lane_write_en == ~$past(s_lane_sel_n);
    endproperty
    a_lane_map: assert property (p_lane_map)
        else $error("Lane enables do not match selects");

    property p_no_write_high;
        @(posedge core_clk) disable iff (rst)
        (!s_qual_n && !s_advance && s_write_n) |=> !access_write;
    endproperty
    a_no_write_high: assert property (p_no_write_high)
        else $error("Write begun with request high");

    property p_advance_low_bits;
        @(posedge core_clk) disable iff (rst)
        (!s_qual_n && s_advance && st_q.sel) |=> access_valid
        && (access_addr[ADDR_W-1:2] == $past(st_q.base[ADDR_W-1:2]))
        && (access_addr[1:0] != $past(st_q.ofs));
    endproperty
    a_advance_low_bits: assert property (p_advance_low_bits)
        else $error("Advance did not step only low bits");

    property p_linear_step;
        @(posedge core_clk) disable iff (rst)
        (!s_qual_n && s_advance && st_q.sel && st_q.mode == 1'b0)
        |=> access_addr[1:0] == $past(st_q.ofs) + 2'h1;
    endproperty
    a_linear_step: assert property (p_linear_step)
        else $error("Linear order step wrong");

    // Interleaved order: start bits xor the burst position
    property p_interleave_step;
        @(posedge core_clk) disable iff (rst)
        (!s_qual_n && s_advance && st_q.sel && st_q.mode == 1'b1)
        |=> access_addr[1:0]
        == ($past(st_q.base[1:0]) ^ ($past(st_q.cnt) + 2'h1));
    endproperty
    a_interleave_step: assert property (p_interleave_step)
        else $error("Interleaved order step wrong");

    c_write: cover property (@(posedge core_clk) disable iff (rst)
        access_write);
    c_burst: cover property (@(posedge core_clk) disable iff (rst)
        access_valid ##1 access_valid ##1 access_valid);
    c_stall: cover property (@(posedge core_clk) disable iff (rst)
        selected ##1 s_qual_n [*3]);
endmodule

// [include/sram_ctl_pkg.sv]
package sram_ctl_pkg;
    // Geometry
    localparam int ADDR_W = 21;
    localparam int LANES = 8;
    localparam int LANE_W = 9;
    localparam int BURST_W = 2;
    // Values after reset
    localparam logic [1:0] BURST_OFS_RST = 2'h0;
    // Burst order strap levels
    localparam logic ORDER_INTERLEAVED = 1'b1;
    localparam logic ORDER_LINEAR = 1'b0;
endpackage

// [verification/ctl_model.sv]
`timescale 1ns/100ps
// Controller model: one qualified edge per request, ignored edges between
module ctl_model (
    input wire logic core_clk,
    output logic [20:2] addr_upper,
    output logic addr_bit_one,
    output logic addr_bit_zero,
    output logic [7:0] lane_write_sel_n,
    output logic write_req_n,
    output logic advance_or_load,
    output logic clock_qualifier_low,
    output logic select_low_first,
    output logic select_high_second,
    output logic select_low_third
);
    // Idle pins request a write but would load with first select high and so deselect if the edge counted
    task automatic idle();
        clock_qualifier_low = 1'b1;
        {addr_upper, addr_bit_one, addr_bit_zero} =
            ~{addr_upper, addr_bit_one, addr_bit_zero};
        lane_write_sel_n = ~lane_write_sel_n;
        write_req_n = 1'b0;
        advance_or_load = 1'b0;
        select_low_first = 1'b1;
    endtask
    // Request pins held for exactly one edge
    task automatic issue(input logic [20:0] a, input logic [7:0] s,
        input logic w, input logic ad, input logic [2:0] cs);
        @(posedge core_clk);
        #1 {addr_upper, addr_bit_one, addr_bit_zero} = a;
        lane_write_sel_n = s;
        write_req_n = w;
        advance_or_load = ad;
        {select_low_first, select_high_second, select_low_third} = cs;
        clock_qualifier_low = 1'b0;
        @(posedge core_clk);
        #1 idle();
    endtask
    // Defined pins from time zero
    initial begin
        {addr_upper, addr_bit_one, addr_bit_zero} = 21'h0;
        lane_write_sel_n = 8'h00;
        select_high_second = 1'b1;
        select_low_third = 1'b0;
        idle();
    end
endmodule

// [verification/sync_sram_control_inputs_bench.sv]
`timescale 1ns/100ps
// Bench: row table of cases, then reset and linear order by hand
module sync_sram_control_inputs_bench;
    typedef struct packed {
        logic [20:0] a;
        logic [7:0] s;
        logic w, ad;
        logic [2:0] cs;
        logic ev, ew;
        logic [20:0] ea;
        logic [7:0] el;
        logic es;
    } row_s;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic burst_order_strap = sram_ctl_pkg::ORDER_INTERLEAVED;
    logic [20:2] addr_upper;
    logic addr_bit_one, addr_bit_zero, write_req_n, advance_or_load;
    logic clock_qualifier_low, select_low_first, select_high_second;
    logic select_low_third, access_valid, access_write, selected;
    logic [7:0] lane_write_sel_n, lane_write_en;
    logic [20:0] access_addr;
    int err_count = 0;
    int tests_run = 0;
    // Selects are {first, second, third}; 3'h2 selects; row 9 reloads
    row_s rows [10] = '{
        '{21'h12345,8'h5a,1'h0,1'h0,3'h2,1'h1,1'h1,21'h12345,8'ha5,1'h1},
        '{21'h00000,8'h5a,1'h0,1'h1,3'h2,1'h1,1'h1,21'h12344,8'ha5,1'h1},
        '{21'h00000,8'h5a,1'h0,1'h1,3'h2,1'h1,1'h1,21'h12347,8'ha5,1'h1},
        '{21'h00ff2,8'h00,1'h1,1'h0,3'h2,1'h1,1'h0,21'h00ff2,8'h00,1'h1},
        '{21'h0abcd,8'h00,1'h0,1'h0,3'h6,1'h0,1'h0,21'h00000,8'h00,1'h0},
        '{21'h0abcd,8'h00,1'h0,1'h1,3'h2,1'h0,1'h0,21'h00000,8'h00,1'h0},
        '{21'h0abcd,8'h00,1'h0,1'h0,3'h0,1'h0,1'h0,21'h00000,8'h00,1'h0},
        '{21'h0abcd,8'h00,1'h0,1'h0,3'h3,1'h0,1'h0,21'h00000,8'h00,1'h0},
        '{21'h1fffff,8'h00,1'h0,1'h0,3'h2,1'h1,1'h1,21'h1fffff,8'hff,1'h1},
        '{21'h00100,8'hff,1'h0,1'h0,3'h2,1'h1,1'h1,21'h00100,8'h00,1'h1}
    };
    always #4 core_clk = ~core_clk;
    ctl_model ctl_i (.core_clk, .addr_upper, .addr_bit_one, .addr_bit_zero,
        .lane_write_sel_n, .write_req_n, .advance_or_load,
        .clock_qualifier_low, .select_low_first, .select_high_second,
        .select_low_third);
    sync_sram_control_inputs sync_sram_control_inputs_i (.core_clk, .rst,
        .addr_upper, .addr_bit_one, .addr_bit_zero, .lane_write_sel_n,
        .write_req_n, .advance_or_load, .clock_qualifier_low,
        .select_low_first, .select_high_second, .select_low_third,
        .burst_order_strap, .access_addr, .access_valid, .access_write,
        .lane_write_en, .selected);
    // Verdict and end of run
    task automatic stop_test();
        if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One comparison
    task automatic chk(input logic [20:0] g, input logic [20:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Reset with a strap level; outputs must read zero
    task automatic do_reset(input logic strap);
        @(posedge core_clk);
        #1 rst = 1'b1;
        burst_order_strap = strap;
        repeat (10) @(posedge core_clk);
        #1 chk(21'({access_valid, access_write, lane_write_en, selected}),
            21'h0);
        chk(access_addr, 21'h0);
        rst = 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    // Issue a case, catch the access pulse in a bounded window
    task automatic run_row(input row_s r);
        logic seen, wr;
        logic [20:0] ad;
        logic [7:0] ln;
        ctl_i.issue(r.a, r.s, r.w, r.ad, r.cs);
        {seen, wr, ad, ln} = '0;
        repeat (6) begin
            @(posedge core_clk);
            #2 if (access_valid === 1'b1 && !seen) begin
                {seen, wr, ad, ln} = {1'b1, access_write, access_addr,
                    lane_write_en};
            end
        end
        chk(21'(seen), 21'(r.ev));
        if (r.ev && !seen) stop_test();
        if (seen) begin
            chk(21'(wr), 21'(r.ew));
            chk(ad, r.ea);
            chk(21'(ln), 21'(r.el));
        end
        chk(21'(selected), 21'(r.es));
    endtask
    initial begin
        do_reset(sram_ctl_pkg::ORDER_INTERLEAVED);
        foreach (rows[i]) run_row(rows[i]);
        do_reset(sram_ctl_pkg::ORDER_LINEAR);
        run_row(row_s'{21'h00001, 8'hff, 1'h1, 1'h0, 3'h2, 1'h1, 1'h0,
            21'h00001, 8'h00, 1'h1});
        run_row(row_s'{21'h00000, 8'hff, 1'h1, 1'h1, 3'h2, 1'h1, 1'h0,
            21'h00002, 8'h00, 1'h1});
        run_row(row_s'{21'h00000, 8'hff, 1'h1, 1'h1, 3'h6, 1'h1, 1'h0,
            21'h00003, 8'h00, 1'h1});
        stop_test();
    end
endmodule
